// *** pkg/eirq_pkg.sv ***
// Constants shared by the external interrupt register block
package eirq_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_LINES = 8;
  localparam int CFG_W = 4;
  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_NMSK_CTL = 5'h02;
  localparam logic [4:0] IDX_NMSK_FLAG = 5'h03;
  localparam logic [4:0] IDX_EVT_OUT_EN = 5'h04;
  localparam logic [4:0] IDX_IRQ_EN_CLR = 5'h08;
  localparam logic [4:0] IDX_IRQ_EN_SET = 5'h0C;
  localparam logic [4:0] IDX_EXT_FLAG = 5'h10;
  localparam logic [4:0] IDX_EXT_CFG = 5'h18;
  // ==========================================================
  // Field positions
  localparam int CTRL_SOFT_RST_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int NMSK_FILT_BIT = 3;
  localparam int NMSK_FLAG_BIT = 0;
  localparam int SENSE_W = 3;
  // ==========================================================
  // Reset values
  localparam logic [3:0] NMSK_CTL_RST = 4'h0;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // ==========================================================
  // Sense codes
  localparam logic [2:0] SNS_NONE = 3'h0;
  localparam logic [2:0] SNS_RISE = 3'h1;
  localparam logic [2:0] SNS_FALL = 3'h2;
  localparam logic [2:0] SNS_BOTH = 3'h3;
  localparam logic [2:0] SNS_HIGH = 3'h4;
  localparam logic [2:0] SNS_LOW = 3'h5;
  // ==========================================================
  // Bus
  localparam logic HRESP_OKAY = 1'b0;
  localparam int HTRANS_ACT_BIT = 1;
endpackage

// *** src/eirq_sense.sv ***
// Per-pin filter and sense detector
`timescale 1ns/1ns
module eirq_sense import eirq_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  input wire logic enable,
  input wire logic pin,
  input wire logic filt_en,
  input wire logic [2:0] sense,
  output logic hit
);
  logic [2:0] smp_ff;
  logic prev_ff;
  wire maj;
  wire lvl;
  wire rise;
  wire fall;
  wire match;

  // Majority of three samples rejects single-cycle glitches
  assign maj = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) |
               (smp_ff[1] & smp_ff[2]);
  assign lvl = filt_en ? maj : pin;
  assign rise = lvl & ~prev_ff;
  assign fall = ~lvl & prev_ff;
  // Reserved codes fall through to no detection
  assign match = (sense == SNS_RISE) ? rise :
                 (sense == SNS_FALL) ? fall :
                 (sense == SNS_BOTH) ? (rise | fall) :
                 (sense == SNS_HIGH) ? lvl :
                 (sense == SNS_LOW) ? ~lvl : 1'b0;
  assign hit = enable & match;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      smp_ff <= 3'h0;
      prev_ff <= 1'b0;
    end else if (clr) begin
      smp_ff <= 3'h0;
      prev_ff <= 1'b0;
    end else begin
      smp_ff <= {smp_ff[1:0], pin};
      prev_ff <= lvl;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_SENSE_RSV: assert property (sense > SNS_LOW |-> !hit)
    else $error("reserved sense code produced a detection");
  AST_FILT_BYPASS: assert property (
    enable && !filt_en && sense == SNS_HIGH |-> hit == pin)
    else $error("unfiltered level sense does not follow pin");
  AST_FILT_MAJ: assert property (
    enable && filt_en && sense == SNS_HIGH && smp_ff == 3'h6
    |-> hit)
    else $error("filtered level ignores sample majority");
endmodule

// *** src/eirq_ctrl.sv ***
// External interrupt controller registers on an AHB-Lite slave
//
// How it works
// - control bit 3 selects filtered nonmaskable input
// - 3-bit sense code picks edge or level
// - nonmaskable match sets flag, always requests
// - writing one clears nonmaskable flag, zero ignored
// - per-pin event output enable bits 7:0
// - enable-clear write of one disables line
// - both enable registers read one shared mask
// - enable-set affects only bits written one
// - reserved bits read zero, software writes zero
// - enable-set write of one enables line
// - line requests only when flagged and enabled
// - soft reset restores registers, disables controller
// - protection blocks guarded register writes
`timescale 1ns/1ns
module eirq_ctrl import eirq_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic prot_active,
  input wire logic nmsk_pin,
  input wire logic [NUM_LINES-1:0] ext_pin,
  output logic nmsk_req,
  output logic ext_irq,
  output logic [NUM_LINES-1:0] ext_event
);
  // ==========================================================
  // State
  logic hready_ff;
  logic [31:0] hrdata_ff;
  logic ph_act_ff;
  logic ph_wr_ff;
  logic ph_map_ff;
  logic [4:0] ph_idx_ff;
  logic ctrl_en_ff;
  logic [3:0] nmsk_ctl_ff;
  logic nmsk_flag_ff;
  logic [NUM_LINES-1:0] evt_en_ff;
  logic [NUM_LINES-1:0] irq_en_ff;
  logic [NUM_LINES-1:0] ext_flag_ff;
  logic [31:0] ext_cfg_ff;
  logic [NUM_LINES-1:0] evt_ff;
  logic nmsk_req_ff;
  logic ext_irq_ff;

  // ==========================================================
  // Bus decode
  wire take;
  wire in_map;
  wire wr_ok;
  wire wp_ok;
  wire rd_ok;
  wire [7:0] wlow;
  wire sel_ctrl;
  wire sel_nctl;
  wire sel_nflag;
  wire sel_evt;
  wire sel_clr;
  wire sel_set;
  wire sel_flag;
  wire sel_cfg;
  wire srst;
  wire [31:0] rd_word;

  // Only one transfer in flight; the wait state lets a write land
  // before any following read is sampled
  assign take = hsel & htrans[HTRANS_ACT_BIT] & hready & hready_ff;
  assign in_map = (haddr[31:7] == 25'h0) & (haddr[1:0] == 2'h0);
  assign wr_ok = ph_act_ff & ph_wr_ff & ph_map_ff;
  assign wp_ok = wr_ok & ~prot_active;
  assign rd_ok = ph_act_ff & ~ph_wr_ff;
  assign wlow = hwdata[7:0];
  assign sel_ctrl = wp_ok & (ph_idx_ff == IDX_CTRL);
  assign sel_nctl = wp_ok & (ph_idx_ff == IDX_NMSK_CTL);
  assign sel_nflag = wr_ok & (ph_idx_ff == IDX_NMSK_FLAG);
  assign sel_evt = wp_ok & (ph_idx_ff == IDX_EVT_OUT_EN);
  assign sel_clr = wp_ok & (ph_idx_ff == IDX_IRQ_EN_CLR);
  assign sel_set = wp_ok & (ph_idx_ff == IDX_IRQ_EN_SET);
  assign sel_flag = wr_ok & (ph_idx_ff == IDX_EXT_FLAG);
  assign sel_cfg = wp_ok & (ph_idx_ff == IDX_EXT_CFG);
  // Soft reset overrides every other field of the same write
  assign srst = sel_ctrl & hwdata[CTRL_SOFT_RST_BIT];

  // Narrow registers sit in the low bits, upper bits read zero
  assign rd_word =
    !ph_map_ff ? 32'h0 :
    (ph_idx_ff == IDX_CTRL) ? {30'h0, ctrl_en_ff, 1'b0} :
    (ph_idx_ff == IDX_NMSK_CTL) ? {28'h0, nmsk_ctl_ff} :
    (ph_idx_ff == IDX_NMSK_FLAG) ? {31'h0, nmsk_flag_ff} :
    (ph_idx_ff == IDX_EVT_OUT_EN) ? {24'h0, evt_en_ff} :
    (ph_idx_ff == IDX_IRQ_EN_CLR) ? {24'h0, irq_en_ff} :
    (ph_idx_ff == IDX_IRQ_EN_SET) ? {24'h0, irq_en_ff} :
    (ph_idx_ff == IDX_EXT_FLAG) ? {24'h0, ext_flag_ff} :
    (ph_idx_ff == IDX_EXT_CFG) ? ext_cfg_ff : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_ff <= 1'b1;
      ph_act_ff <= 1'b0;
      ph_wr_ff <= 1'b0;
      ph_map_ff <= 1'b0;
      ph_idx_ff <= IDX_CTRL;
    end else begin
      hready_ff <= ~take;
      ph_act_ff <= take;
      if (take) begin
        ph_wr_ff <= hwrite;
        ph_map_ff <= in_map;
        ph_idx_ff <= haddr[6:2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (rd_ok) begin
      hrdata_ff <= rd_word;
    end
  end

  // ==========================================================
  // Pin detection
  wire nmsk_hit;
  wire [NUM_LINES-1:0] ext_hit;

  eirq_sense u_nmsk (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(srst),
    .enable(ctrl_en_ff),
    .pin(nmsk_pin),
    .filt_en(nmsk_ctl_ff[NMSK_FILT_BIT]),
    .sense(nmsk_ctl_ff[SENSE_W-1:0]),
    .hit(nmsk_hit)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
      eirq_sense u_line (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(srst),
        .enable(ctrl_en_ff),
        .pin(ext_pin[gi]),
        .filt_en(ext_cfg_ff[gi*CFG_W+SENSE_W]),
        .sense(ext_cfg_ff[gi*CFG_W +: SENSE_W]),
        .hit(ext_hit[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Next values; a detection beats a write-one clear, soft reset beats both
  wire nxt_nmsk_flag;
  wire [NUM_LINES-1:0] nxt_ext_flag;
  wire [NUM_LINES-1:0] nxt_irq_en;
  wire [NUM_LINES-1:0] clr_mask;
  wire [NUM_LINES-1:0] set_mask;
  wire [NUM_LINES-1:0] flag_clr;

  assign clr_mask = sel_clr ? wlow : LINE_RST;
  assign set_mask = sel_set ? wlow : LINE_RST;
  assign flag_clr = sel_flag ? wlow : LINE_RST;
  assign nxt_nmsk_flag = srst ? 1'b0 :
    nmsk_hit | (nmsk_flag_ff &
    ~(sel_nflag & hwdata[NMSK_FLAG_BIT]));
  assign nxt_ext_flag = srst ? LINE_RST :
    ext_hit | (ext_flag_ff & ~flag_clr);
  assign nxt_irq_en = srst ? LINE_RST :
    (irq_en_ff & ~clr_mask) | set_mask;

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_ff <= 1'b0;
      nmsk_ctl_ff <= NMSK_CTL_RST;
      evt_en_ff <= LINE_RST;
      ext_cfg_ff <= CFG_RST;
    end else if (srst) begin
      ctrl_en_ff <= 1'b0;
      nmsk_ctl_ff <= NMSK_CTL_RST;
      evt_en_ff <= LINE_RST;
      ext_cfg_ff <= CFG_RST;
    end else begin
      if (sel_ctrl) begin
        ctrl_en_ff <= hwdata[CTRL_ENABLE_BIT];
      end
      if (sel_nctl) begin
        nmsk_ctl_ff <= hwdata[3:0];
      end
      if (sel_evt) begin
        evt_en_ff <= wlow;
      end
      if (sel_cfg) begin
        ext_cfg_ff <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmsk_flag_ff <= 1'b0;
      ext_flag_ff <= LINE_RST;
      irq_en_ff <= LINE_RST;
    end else begin
      nmsk_flag_ff <= nxt_nmsk_flag;
      ext_flag_ff <= nxt_ext_flag;
      irq_en_ff <= nxt_irq_en;
    end
  end

  // ==========================================================
  // Outputs, all registered except hresp, which is tied to OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_ff <= LINE_RST;
      nmsk_req_ff <= 1'b0;
      ext_irq_ff <= 1'b0;
    end else begin
      evt_ff <= srst ? LINE_RST : (ext_hit & evt_en_ff);
      nmsk_req_ff <= nxt_nmsk_flag;
      ext_irq_ff <= |(nxt_ext_flag & nxt_irq_en);
    end
  end

  assign hreadyout = hready_ff;
  assign hrdata = hrdata_ff;
  assign hresp = HRESP_OKAY;
  assign nmsk_req = nmsk_req_ff;
  assign ext_irq = ext_irq_ff;
  assign ext_event = evt_ff;

  // ==========================================================
  // Checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_mask;
    take && !hwrite && in_map &&
    (haddr[6:2] == IDX_IRQ_EN_CLR || haddr[6:2] == IDX_IRQ_EN_SET);
  endsequence

  sequence s_answer;
    ##1 !hreadyout ##1 hreadyout;
  endsequence

  AST_MASK_MIRROR: assert property (
    s_rd_mask |-> s_answer ##0
    (hrdata[7:0] == $past(irq_en_ff) && hrdata[31:8] == 24'h0))
    else $error("enable mask read mismatch");

  AST_NMSK_SET: assert property (
    nmsk_hit && !srst |=> nmsk_flag_ff && nmsk_req)
    else $error("nonmaskable match did not set flag");

  AST_NMSK_W1C: assert property (
    sel_nflag && hwdata[NMSK_FLAG_BIT] && !nmsk_hit |=> !nmsk_req)
    else $error("nonmaskable flag not cleared by one");

  AST_NMSK_W0: assert property (
    sel_nflag && !hwdata[NMSK_FLAG_BIT] && nmsk_flag_ff |=> nmsk_req)
    else $error("nonmaskable flag cleared by zero");

  AST_EVT_OUT: assert property (
    !srst |=> ext_event == ($past(ext_hit) & $past(evt_en_ff)))
    else $error("event output does not follow enable");

  AST_EN_CLR: assert property (
    sel_clr && !srst |=>
    irq_en_ff == ($past(irq_en_ff) & ~$past(wlow)))
    else $error("enable clear wrong");

  AST_EN_SET: assert property (
    sel_set && !srst |=>
    irq_en_ff == ($past(irq_en_ff) | $past(wlow)))
    else $error("enable set wrong");

  AST_LINE_IRQ: assert property (
    ext_irq == |(ext_flag_ff & irq_en_ff))
    else $error("line request not gated by enable");

  AST_SOFT_RST: assert property (
    srst |=> !ctrl_en_ff && irq_en_ff == LINE_RST &&
    nmsk_ctl_ff == NMSK_CTL_RST && evt_en_ff == LINE_RST)
    else $error("soft reset left state behind");

  AST_PROT: assert property (
    wr_ok && prot_active |=> $stable(nmsk_ctl_ff) &&
    $stable(evt_en_ff) && $stable(ctrl_en_ff))
    else $error("protected register changed");
endmodule

// *** tb/eirq_pin_model.sv ***
// Behavioural model of the external interrupt pins
`timescale 1ns/1ns
module eirq_pin_model import eirq_pkg::*; (
  input wire logic hclk,
  input wire logic nmsk_lvl,
  input wire logic [NUM_LINES-1:0] ext_lvl,
  output logic nmsk_pin,
  output logic [NUM_LINES-1:0] ext_pin
);
  // ==========================================================
  // Pins
  // Pads change only after a clock edge, as a synchronised source would
  initial begin
    nmsk_pin = 1'b0;
    ext_pin = '0;
  end
  always @(posedge hclk) begin
    nmsk_pin <= nmsk_lvl;
    ext_pin <= ext_lvl;
  end
endmodule

// *** tb/eirq_ctrl_bench.sv ***
// Self-checking bench for the external interrupt register block
`timescale 1ns/1ns
module eirq_ctrl_bench import eirq_pkg::*;;
  // ==========================================================
  // Signals
  typedef struct packed {
    logic w;
    logic [4:0] idx;
    logic [31:0] d;
    logic [31:0] e;
  } eirq_row_s;
  logic hclk, hresetn, hsel, hwrite, prot_active, nmsk_lvl;
  logic hreadyout, hresp, nmsk_req, ext_irq, nmsk_pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [NUM_LINES-1:0] ext_lvl, ext_pin, ext_event;
  int fails, total_checks;
  localparam logic [7:0] EXP_A = 8'h3A;
  localparam logic [7:0] EXP_B = 8'h3C;
  localparam eirq_row_s ROWS [10] = '{
    '{1'b0, IDX_NMSK_CTL, 32'h0, 32'h0},
    '{1'b1, IDX_NMSK_CTL, 32'hFFFFFFFF, 32'h0000000F},
    '{1'b1, IDX_EVT_OUT_EN, 32'hFFFFFFFF, 32'h000000FF},
    '{1'b1, IDX_IRQ_EN_SET, 32'h00000005, 32'h00000005},
    '{1'b0, IDX_IRQ_EN_CLR, 32'h0, 32'h00000005},
    '{1'b1, IDX_IRQ_EN_SET, 32'h00000002, 32'h00000007},
    '{1'b1, IDX_IRQ_EN_CLR, 32'h00000004, 32'h00000003},
    '{1'b0, IDX_IRQ_EN_SET, 32'h0, 32'h00000003},
    '{1'b1, 5'h1F, 32'hFFFFFFFF, 32'h0},
    '{1'b1, IDX_NMSK_FLAG, 32'hFFFFFFFE, 32'h0}
  };
  eirq_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .prot_active(prot_active),
    .nmsk_pin(nmsk_pin), .ext_pin(ext_pin), .nmsk_req(nmsk_req),
    .ext_irq(ext_irq), .ext_event(ext_event));
  eirq_pin_model i_pins (.hclk(hclk), .nmsk_lvl(nmsk_lvl),
    .ext_lvl(ext_lvl), .nmsk_pin(nmsk_pin), .ext_pin(ext_pin));
  // ==========================================================
  // Tasks
  task automatic end_of_test;
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Outputs that must sit at their idle level while reset holds
  task automatic rst_chk;
    chk({28'h0, hresp, hreadyout, nmsk_req, ext_irq}, 32'h4);
    chk({24'h0, ext_event}, 32'h0);
  endtask
  // Samples hready at each edge; the bound turns a hang into a failure
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      end_of_test;
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] idx,
    input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {25'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pulse(input int n);
    nmsk_lvl <= 1'b1;
    settle(n);
    nmsk_lvl <= 1'b0;
    settle(6);
  endtask
  // ==========================================================
  // Stimulus
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, prot_active, nmsk_lvl} = '0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    ext_lvl = '0;
    fails = 0;
    total_checks = 0;
    settle(3);
    rst_chk;
    hresetn <= 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w)
        bus(1'b1, ROWS[i].idx, ROWS[i].d, r);
      bus(1'b0, ROWS[i].idx, 32'h0, r);
      chk(r, ROWS[i].e);
    end
    bus(1'b1, IDX_CTRL, 32'h2, r);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, IDX_NMSK_CTL, 32'(c), r);
      bus(1'b1, IDX_NMSK_FLAG, 32'h1, r);
      nmsk_lvl <= 1'b1;
      settle(5);
      bus(1'b1, IDX_NMSK_FLAG, 32'h0, r);
      bus(1'b0, IDX_NMSK_FLAG, 32'h0, r);
      chk(r, {31'h0, EXP_A[c]});
      chk({31'h0, nmsk_req}, {31'h0, EXP_A[c]});
      bus(1'b1, IDX_NMSK_FLAG, 32'h1, r);
      nmsk_lvl <= 1'b0;
      settle(5);
      bus(1'b0, IDX_NMSK_FLAG, 32'h0, r);
      chk(r, {31'h0, EXP_B[c]});
    end
    // Single-sample glitch must pass only with the filter off
    for (int f = 0; f < 4; f++) begin
      r = (f == 3) ? 32'hC : (f == 0) ? 32'h1 : 32'h9;
      bus(1'b1, IDX_NMSK_CTL, r, r);
      bus(1'b1, IDX_NMSK_FLAG, 32'h1, r);
      pulse((f >= 2) ? 4 : 1);
      bus(1'b0, IDX_NMSK_FLAG, 32'h0, r);
      chk(r, (f == 1) ? 32'h0 : 32'h1);
    end
    bus(1'b1, IDX_EXT_CFG, 32'h11111111, r);
    bus(1'b1, IDX_EVT_OUT_EN, 32'h0000000F, r);
    ext_lvl <= 8'hFF;
    for (int n = 0; n < 8 && ext_event === '0; n++)
      @(posedge hclk);
    chk({24'h0, ext_event}, 32'h0F);
    @(posedge hclk);
    chk({24'h0, ext_event}, 32'h0);
    settle(2);
    chk({31'h0, ext_irq}, 32'h1);
    bus(1'b0, IDX_EXT_FLAG, 32'h0, r);
    chk(r, 32'h000000FF);
    bus(1'b1, IDX_IRQ_EN_CLR, 32'h000000FF, r);
    settle(2);
    chk({31'h0, ext_irq}, 32'h0);
    prot_active <= 1'b1;
    bus(1'b1, IDX_EVT_OUT_EN, 32'h0, r);
    bus(1'b1, IDX_IRQ_EN_SET, 32'h000000FF, r);
    prot_active <= 1'b0;
    bus(1'b0, IDX_EVT_OUT_EN, 32'h0, r);
    chk(r, 32'h0F);
    bus(1'b0, IDX_IRQ_EN_SET, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b1, IDX_CTRL, 32'h1, r);
    foreach (ROWS[i]) begin
      bus(1'b0, ROWS[i].idx, 32'h0, r);
      chk(r, 32'h0);
    end
    bus(1'b0, IDX_CTRL, 32'h0, r);
    chk(r, 32'h0);
    // Hard reset in mid-run must drop a standing request and the registers
    bus(1'b1, IDX_CTRL, 32'h2, r);
    bus(1'b1, IDX_EVT_OUT_EN, 32'h000000A5, r);
    bus(1'b1, IDX_NMSK_CTL, 32'h4, r);
    nmsk_lvl <= 1'b1;
    settle(4);
    chk({31'h0, nmsk_req}, 32'h1);
    hresetn <= 1'b0;
    settle(2);
    rst_chk;
    hresetn <= 1'b1;
    bus(1'b0, IDX_EVT_OUT_EN, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, IDX_NMSK_FLAG, 32'h0, r);
    chk(r, 32'h0);
    end_of_test;
  end
endmodule
